// [design/cgp_encoder_top.sv]
// Current gauge PWM encoder: averages the modulator bitstream per slot and
// turns the result into a PWM duty cycle on one pin.
// Assumes inputs are synchronous to mclk and one modulator bit per cycle.
//
// What this block does
// - The density bitstream is filtered into a multi-bit averaged current value.
// - The PWM pin comes from comparing that value with a free-running ramp counter.
// - Zero current gives half duty, above half is positive and below half negative.
// - Positive and negative full scale give the symmetric upper and lower duty limits.
// - Current equals 2.2 times duty minus one half times the full-scale current.
// - Full scale is a fixed build option of one or ten amperes.
// - The bitstream is averaged over fixed slots with one new value per slot.
// - Duty is quantised to 128 levels and a new code is loaded whole at the period boundary.
// - A code N gives a high time of N plus one half ramp steps.
// - The duty in a period shows the last slot average captured before the wrap cycle that ended the previous period.
// - While the stop input is low the block rests in a low-power state.
// - The waveform repeats at the clock divided down by the prescaler step length times the 128-step ramp.
`timescale 1ns/1ps
module cgp_encoder_top #(
  parameter int SLOT_CYC = cgp_pkg::SLOT_CYC_DEF,        // Averaging slot in cycles
  parameter int FULL_SCALE_A = cgp_pkg::FULL_SCALE_A_DEF // 1 or 10 amperes
) (
  input wire logic mclk,                           // System clock, 40 MHz
  input wire logic rstn,                           // Async reset, active low
  input wire logic lowPowerStopN,                  // Low-power stop, active low
  input wire logic dsBit,                          // Modulator density bit
  output logic pwmOut,                             // Duty encoded current
  output logic [cgp_pkg::CODE_W-1:0] pwmCode,      // Code now on the pin
  output logic rangeTenAmp                         // High for the ten ampere build
);

  // ==========================================================
  // State
  typedef struct packed {
    cgp_pkg::cgp_state_e state;
    logic [cgp_pkg::PRE_W-1:0] pre;
    logic [cgp_pkg::CODE_W-1:0] ramp;
    logic [cgp_pkg::CODE_W-1:0] cmp;
    logic [cgp_pkg::CODE_W-1:0] pend;
    logic pendValid;
    logic pwm;
  } cgp_enc_s;

  localparam cgp_enc_s ENC_RST = '{
    state: cgp_pkg::ST_IDLE,
    pre: '0,
    ramp: '0,
    cmp: cgp_pkg::CODE_ZERO,
    pend: cgp_pkg::CODE_ZERO,
    pendValid: 1'b0,
    pwm: 1'b0
  };

  cgp_enc_s s_q;
  cgp_enc_s s_d;
  logic stepEnd;
  logic wrap;

  cgp_filt_if filt ();

  // ==========================================================
  // Slot averaging filter
  cgp_slot_filter #(
    .SLOT_CYC(SLOT_CYC)
  ) u_filter (
    .mclk(mclk),
    .rstn(rstn),
    .fp(filt.filt)
  );

  // Filter runs only outside the stop state
  assign filt.enable = lowPowerStopN && (s_q.state != cgp_pkg::ST_IDLE);
  assign filt.dsBit = dsBit;

  // Ramp step and period boundaries
  assign stepEnd = (s_q.pre == cgp_pkg::STEP_LAST);
  assign wrap = stepEnd && (s_q.ramp == '1);

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    case (s_q.state)
      cgp_pkg::ST_IDLE: begin
        s_d = ENC_RST;
        if (lowPowerStopN) begin
          s_d.state = cgp_pkg::ST_WARM;
        end
      end
      cgp_pkg::ST_WARM, cgp_pkg::ST_RUN: begin
        // Prescaler divides mclk into ramp steps
        if (stepEnd) begin
          s_d.pre = '0;
          s_d.ramp = s_q.ramp + 1'b1;
        end else begin
          s_d.pre = s_q.pre + 1'b1;
        end
        // Compare register changes only at the period boundary, or when stop resets it to the zero code
        if (wrap && s_q.pendValid) begin
          s_d.cmp = s_q.pend;
          s_d.pendValid = 1'b0;
        end
        // A finished slot wins over the clear done at the same wrap
        if (filt.slotDone) begin
          s_d.pend = filt.slotCode;
          s_d.pendValid = 1'b1;
          s_d.state = cgp_pkg::ST_RUN;
        end
        // Ramp below code is high, the matching step adds half a step
        s_d.pwm = (s_q.ramp < s_q.cmp) ||
                  ((s_q.ramp == s_q.cmp) && (s_q.pre < cgp_pkg::HALF_CYC));
        if (!lowPowerStopN) begin
          s_d = ENC_RST;
        end
      end
      default: begin
        s_d = ENC_RST;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= ENC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign pwmOut = s_q.pwm;
  assign pwmCode = s_q.cmp;
  assign rangeTenAmp = (FULL_SCALE_A == 10);

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  localparam int LEVEL_MAX = cgp_pkg::PWM_LEVELS - 1;
  localparam int SPAN_LO = 64 - cgp_pkg::CODE_SPAN;
  localparam int SPAN_HI = 64 + cgp_pkg::CODE_SPAN;

  a_stop_forces_low: assert property (!lowPowerStopN |=> !pwmOut && s_q.state == cgp_pkg::ST_IDLE)
    else $error("stop did not force the idle state");

  a_warm_zero_code: assert property (s_q.state == cgp_pkg::ST_WARM |-> pwmCode == cgp_pkg::CODE_ZERO)
    else $error("non-zero code before first slot");

  a_cmp_at_wrap: assert property (pwmCode != $past(pwmCode) && $past(lowPowerStopN)
    |-> $past(wrap))
    else $error("compare changed away from a wrap");

  a_wrap_loads: assert property (wrap && s_q.pendValid && lowPowerStopN
    |=> pwmCode == $past(s_q.pend))
    else $error("pending code not loaded at wrap");

  a_slot_captured: assert property (filt.slotDone && lowPowerStopN
    |=> s_q.pendValid && s_q.pend == $past(filt.slotCode))
    else $error("slot result not captured");

  a_ramp_below_high: assert property (lowPowerStopN && s_q.state != cgp_pkg::ST_IDLE
    && s_q.ramp < s_q.cmp |=> pwmOut)
    else $error("pin low while ramp below code");

  a_ramp_above_low: assert property (s_q.ramp > s_q.cmp |=> !pwmOut)
    else $error("pin high while ramp above code");

  a_half_step: assert property (lowPowerStopN && s_q.state != cgp_pkg::ST_IDLE
    && s_q.ramp == s_q.cmp && s_q.pre == cgp_pkg::HALF_CYC - 1'b1
    |=> pwmOut ##1 !pwmOut)
    else $error("half step high time wrong");

  a_ramp_step: assert property (lowPowerStopN && s_q.state != cgp_pkg::ST_IDLE && stepEnd
    |=> s_q.pre == '0 && s_q.ramp == $past(s_q.ramp) + 1'b1)
    else $error("ramp step length wrong");

  a_code_limits: assert property (int'(pwmCode) >= SPAN_LO && int'(pwmCode) <= SPAN_HI
    && int'(pwmCode) <= LEVEL_MAX)
    else $error("code outside full scale range");

  a_state_onehot: assert property ($onehot(s_q.state))
    else $error("state not one-hot");

  c_slot_done: cover property (filt.slotDone);
  c_wrap_load: cover property (wrap && s_q.pendValid);
  c_stop_in_run: cover property (s_q.state == cgp_pkg::ST_RUN && !lowPowerStopN);
  c_positive_code: cover property (pwmCode > cgp_pkg::CODE_ZERO);

endmodule : cgp_encoder_top

// [design/cgp_pkg.sv]
// Shared constants and types of the current gauge PWM encoder.
// Assumes one 40 MHz clock; all counts below derive from that rate.
package cgp_pkg;

  // ==========================================================
  // Clock and PWM timing
  localparam int CLK_HZ = 40_000_000;          // Mclk rate
  localparam int PWM_FREQ_HZ = 160;            // Nominal PWM repeat rate
  localparam int PWM_LEVELS = 128;             // Ramp steps per period
  localparam int CODE_W = 7;                   // Duty code width
  localparam int STEP_CYC = CLK_HZ / (PWM_FREQ_HZ * PWM_LEVELS);  // 1953
  localparam int PRE_W = $clog2(STEP_CYC);
  localparam logic [PRE_W-1:0] STEP_LAST = PRE_W'(STEP_CYC - 1);
  localparam logic [PRE_W-1:0] HALF_CYC = PRE_W'(STEP_CYC / 2);  // Half ramp step

  // ==========================================================
  // Averaging slot
  localparam int SLOT_MS = 6;                  // Averaging slot length
  localparam int SLOT_CYC_DEF = (CLK_HZ / 1000) * SLOT_MS;

  // ==========================================================
  // Duty code mapping: code - 64 = 128 * (I / Ifs) / 2.2
  localparam logic [CODE_W-1:0] CODE_ZERO = 7'h40;   // Zero current code
  localparam int CODE_SPAN = 58;               // Full scale code swing
  localparam int DUTY_SLOPE_X10 = 22;          // 2.2 written as tenths
  localparam int GAIN_FRAC = 24;               // Fixed point fraction bits
  localparam int FULL_SCALE_A_DEF = 1;         // Build option, 1 or 10 amperes

  // ==========================================================
  // Control states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WARM = 3'h2,
    ST_RUN = 3'h4
  } cgp_state_e;

endpackage : cgp_pkg

// [design/cgp_filt_if.sv]
// Link between the encoder control and the slot averaging filter.
// Assumes both ends share mclk; slotDone is a one-cycle pulse.
`timescale 1ns/1ps
interface cgp_filt_if;
  logic enable;                              // Filter runs while high
  logic dsBit;                               // Modulator density bit
  logic slotDone;                            // Slot finished pulse
  logic [cgp_pkg::CODE_W-1:0] slotCode;      // Averaged duty code

  modport ctrl (output enable, output dsBit, input slotDone, input slotCode);
  modport filt (input enable, input dsBit, output slotDone, output slotCode);
endinterface : cgp_filt_if

// [design/cgp_slot_filter.sv]
// Slot averaging filter: counts the density stream over one slot and
// scales the result to a duty code. Assumes one modulator bit per mclk.
`timescale 1ns/1ps
module cgp_slot_filter #(
  parameter int SLOT_CYC = cgp_pkg::SLOT_CYC_DEF
) (
  input wire logic mclk,          // System clock
  input wire logic rstn,          // Async reset, active low
  cgp_filt_if.filt fp             // Control side link
);

  localparam int CNT_W = $clog2(SLOT_CYC);
  localparam int ACC_W = CNT_W + 2;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SLOT_CYC - 1);
  localparam logic signed [ACC_W-1:0] ACC_ONE = 1;
  // Code offset per unit of the up/down sum, fixed point
  localparam logic signed [63:0] GAIN =
    (64'(cgp_pkg::PWM_LEVELS) * 64'sd10 <<< cgp_pkg::GAIN_FRAC) /
    (64'(cgp_pkg::DUTY_SLOPE_X10) * 64'(SLOT_CYC));
  localparam logic signed [63:0] ROUND_HALF = 64'sd1 <<< (cgp_pkg::GAIN_FRAC - 1);
  localparam logic signed [63:0] SPAN = 64'(cgp_pkg::CODE_SPAN);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic signed [ACC_W-1:0] acc;
    logic done;
    logic [cgp_pkg::CODE_W-1:0] code;
  } cgp_filt_s;

  localparam cgp_filt_s FILT_RST = '{cnt: '0, acc: '0, done: 1'b0, code: cgp_pkg::CODE_ZERO};

  cgp_filt_s s_q;
  cgp_filt_s s_d;
  logic signed [ACC_W-1:0] accNext;
  logic signed [63:0] offs;

  // ==========================================================
  // Up/down density sum and slot end scaling
  always_comb begin
    s_d = s_q;
    accNext = s_q.acc + (fp.dsBit ? ACC_ONE : -ACC_ONE);
    offs = ((64'(accNext) * GAIN) + ROUND_HALF) >>> cgp_pkg::GAIN_FRAC;
    if (offs > SPAN) begin
      offs = SPAN;
    end else if (offs < -SPAN) begin
      offs = -SPAN;
    end
    s_d.done = 1'b0;
    if (!fp.enable) begin
      s_d = FILT_RST;
    end else if (s_q.cnt == CNT_LAST) begin
      s_d.cnt = '0;
      s_d.acc = '0;
      s_d.done = 1'b1;
      s_d.code = cgp_pkg::CODE_ZERO + offs[cgp_pkg::CODE_W-1:0];
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
      s_d.acc = accNext;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= FILT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign fp.slotDone = s_q.done;
  assign fp.slotCode = s_q.code;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_slot_end_pulse: assert property (fp.enable && s_q.cnt == CNT_LAST |=> s_q.done)
    else $error("slot end did not raise done");
  a_done_spacing: assert property (s_q.done |=> !s_q.done)
    else $error("done held longer than one cycle");

endmodule : cgp_slot_filter

// [verification/cgp_duty_meter.sv]
// Partner model: logic that times the PWM pin and reads the code back.
// Assumes pwmIn is synchronous to mclk and the package step length holds.
`timescale 1ns/1ps
module cgp_duty_meter (
  input wire logic mclk,   // System clock
  input wire logic rstn,   // Async reset, active low
  input wire logic pwmIn,  // PWM pin under test
  output int highCycles,   // Last high time in cycles
  output int periodCycles, // Last rise to rise span
  output int rises,        // Rising edges seen
  output int falls,        // Falling edges seen
  output int codeEst,      // Code read back from duty
  output int avgCode       // Mean of the last two readings
);
  // ==========================================================
  // Edge timing
  logic pwmPrev;
  int hiCnt;
  int perCnt;
  // Count samples, latch the spans at each edge
  always @(posedge mclk or negedge rstn) begin : meter
    longint per;
    longint corr;
    int code;
    per = cgp_pkg::PWM_LEVELS * cgp_pkg::STEP_CYC;
    if (!rstn) begin
      pwmPrev <= 1'b0;
      hiCnt <= 0;
      perCnt <= 0;
      rises <= 0;
      falls <= 0;
      codeEst <= 0;
      avgCode <= 0;
    end else begin
      pwmPrev <= pwmIn;
      hiCnt <= pwmIn ? hiCnt + 1 : 0;
      perCnt <= (pwmIn && !pwmPrev) ? 1 : perCnt + 1;
      if (pwmIn && !pwmPrev) begin
        periodCycles <= perCnt;
        rises <= rises + 1;
      end
      if (!pwmIn && pwmPrev) begin
        // Remove the half-step offset, then round to a code
        corr = longint'(hiCnt) * 256 - per;
        code = int'((corr * 128 + 128 * per) / (256 * per));
        highCycles <= hiCnt;
        codeEst <= code;
        avgCode <= (code + codeEst) / 2;
        falls <= falls + 1;
      end
    end
  end
endmodule : cgp_duty_meter

// [verification/testbench.sv]
// Testbench of the PWM encoder: drives stop and bitstream, reads the pin.
// Assumes a short averaging slot; the PWM step length is fixed.
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Signals and constants
  localparam int SLOT = 64;
  localparam int STEP = cgp_pkg::STEP_CYC;
  localparam int PERIOD = 128 * STEP;
  localparam int EXP_POS = 64 + int'(128.0 / 2.2);
  localparam int EXP_NEG = 64 - int'(128.0 / 2.2);
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic lowPowerStopN = 1'b1;
  logic dsBit = 1'b1;
  logic pwmOut;
  logic [cgp_pkg::CODE_W-1:0] pwmCode;
  logic rangeTenAmp;
  int highCycles, periodCycles, rises, falls, codeEst, avgCode;
  int bad_count = 0;
  int total_checks = 0;
  // Clock of 25 ns
  always #12.5 mclk = ~mclk;
  cgp_encoder_top #(.SLOT_CYC(SLOT), .FULL_SCALE_A(1)) cgp_encoder_top_inst (
    .mclk(mclk), .rstn(rstn), .lowPowerStopN(lowPowerStopN), .dsBit(dsBit),
    .pwmOut(pwmOut), .pwmCode(pwmCode), .rangeTenAmp(rangeTenAmp));
  cgp_duty_meter cgp_duty_meter_inst (
    .mclk(mclk), .rstn(rstn), .pwmIn(pwmOut), .highCycles(highCycles),
    .periodCycles(periodCycles), .rises(rises), .falls(falls),
    .codeEst(codeEst), .avgCode(avgCode));
  // ==========================================================
  // Compare and wait helpers
  task automatic fail(input string msg);
    bad_count++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail
  task automatic check_bit(input logic exp, input logic got, input string what);
    total_checks++;
    if (got !== exp) fail(what);
  endtask : check_bit
  task automatic check_code(input logic [6:0] exp, input logic [6:0] got);
    total_checks++;
    if (got !== exp) fail($sformatf("pwmCode %0h want %0h", got, exp));
  endtask : check_code
  task automatic check_int(input int exp, input int got, input string what);
    total_checks++;
    if (got != exp) fail($sformatf("%s %0d want %0d", what, got, exp));
  endtask : check_int
  function automatic int exp_high(input int n);
    return n * STEP + STEP / 2;
  endfunction : exp_high
  // Wait for the next pin edge seen by the meter, bounded
  task automatic wait_edge(input bit rise, input int limit);
    int start;
    start = rise ? rises : falls;
    for (int i = 0; i < limit; i++) begin
      @(posedge mclk);
      if ((rise ? rises : falls) != start) return;
    end
    fail("pin edge missing");
  endtask : wait_edge
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // ==========================================================
  // Scenarios
  task automatic test_reset();
    repeat (2) @(posedge mclk);
    #1;
    check_bit(1'b0, pwmOut, "pin high in reset");
    check_code(7'h40, pwmCode);
    check_bit(1'b0, rangeTenAmp, "range flag");
    @(posedge mclk);
    rstn <= 1'b1;
    $display("test_reset done");
  endtask : test_reset
  task automatic test_zero_period();
    wait_edge(1'b0, 130000);
    check_int(exp_high(64), highCycles, "zero high");
    check_int(64, codeEst, "zero reading");
    check_code(7'h40, pwmCode);
    wait_edge(1'b1, 130000);
    check_int(PERIOD, periodCycles, "period");
    check_code(7'(EXP_POS), pwmCode);
    dsBit <= 1'b0;
    $display("test_zero_period done");
  endtask : test_zero_period
  task automatic test_full_scale();
    wait_edge(1'b0, 250000);
    check_int(exp_high(EXP_POS), highCycles, "top high");
    check_code(7'(EXP_POS), pwmCode);
    wait_edge(1'b1, 20000);
    check_int(PERIOD, periodCycles, "period");
    check_code(7'(EXP_NEG), pwmCode);
    wait_edge(1'b0, 20000);
    check_int(exp_high(EXP_NEG), highCycles, "bottom high");
    check_int(EXP_NEG, codeEst, "bottom reading");
    check_int((EXP_POS + EXP_NEG) / 2, avgCode, "mean reading");
    $display("test_full_scale done");
  endtask : test_full_scale
  task automatic test_stop();
    @(posedge mclk);
    lowPowerStopN <= 1'b0;
    dsBit <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_bit(1'b0, pwmOut, "pin high in stop");
    check_code(7'h40, pwmCode);
    repeat (200) @(posedge mclk);
    #1;
    check_bit(1'b0, pwmOut, "pin high in stop");
    @(posedge mclk);
    lowPowerStopN <= 1'b1;
    wait_edge(1'b1, 10);
    check_code(7'h40, pwmCode);
    wait_edge(1'b0, 130000);
    check_int(exp_high(64), highCycles, "restart high");
    $display("test_stop done");
  endtask : test_stop
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    test_reset();
    test_zero_period();
    test_full_scale();
    test_stop();
    stop_test();
  end
  initial begin
    #20_000_000;
    fail("watchdog expired");
    stop_test();
  end
endmodule : testbench
